/* midrange_peripheral_chip_select.sv */
// Midrange and upper peripheral chip-select generator with APB registers
`include "select_map.svh"
`default_nettype none

module midrange_peripheral_chip_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cycle_start,
	input wire logic [19:0] cycle_addr,
	input wire logic cycle_is_mem,
	input wire logic [8:0] peripheral_base,
	input wire logic peripheral_base_written,
	input wire logic ext_ready,
	output logic cycle_done,
	output logic [3:0] midrange_selects_n,
	output logic [1:0] upper_peripheral_selects_n
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Position of the one-hot size bit, 0 for 8K total
	function automatic logic [2:0] size_index(input logic [6:0] size_field);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (size_field[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : size_index

	// Address bits a19..a13 that fall inside the block
	function automatic logic [6:0] block_mask(input logic [6:0] size_field);
		logic [6:0] mask;
		mask = 7'h00;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(size_index(size_field))) begin
				mask[i] = 1'b1;
			end
		end
		return mask;
	endfunction : block_mask

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [6:0] mid_base_q;
	logic mid_rdy_ignore_q;
	select_pkg::wait_count_t mid_ws_q;
	logic [6:0] block_size_q;
	logic pin_function_q;
	logic space_q;
	logic aux_rdy_ignore_q;
	select_pkg::wait_count_t aux_ws_q;
	logic mid_written_q;
	logic aux_written_q;
	logic aux_accessed_q;

	logic setup_phase;
	logic access_done;
	logic hit_mid_cfg;
	logic hit_aux_cfg;
	logic wr_mid;
	logic wr_aux;

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;
	assign hit_mid_cfg = (paddr == `MID_CFG_ADDR);
	assign hit_aux_cfg = (paddr == `AUX_CFG_ADDR);
	assign wr_mid = access_done && pwrite && hit_mid_cfg;
	assign wr_aux = access_done && pwrite && hit_aux_cfg;

	// ****************************************************************
	// APB slave: one wait-free access phase per transfer
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup_phase && !hit_mid_cfg && !hit_aux_cfg;
		end
	end

	// Reserved bits read back as ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `UNMAPPED_DATA;
		end else if (setup_phase) begin
			if (hit_mid_cfg) begin
				prdata <= {16'h0000, `MID_RSVD_ONES | {mid_base_q, 6'h00, mid_rdy_ignore_q, mid_ws_q}};
			end else if (hit_aux_cfg) begin
				prdata <= {16'h0000, `AUX_RSVD_ONES | {1'b0, block_size_q, pin_function_q, space_q,
					3'h0, aux_rdy_ignore_q, aux_ws_q}};
			end else begin
				prdata <= `UNMAPPED_DATA;
			end
		end
	end

	// Contents cleared for determinism only; activation flags gate use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mid_base_q <= 7'h00;
			mid_rdy_ignore_q <= 1'b0;
			mid_ws_q <= 2'h0;
		end else if (wr_mid) begin
			mid_base_q <= pwdata[`MID_BASE_HI:`MID_BASE_LO];
			mid_rdy_ignore_q <= pwdata[`RDY_IGNORE_BIT];
			mid_ws_q <= pwdata[`WS_HI:`WS_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_size_q <= 7'h00;
			pin_function_q <= 1'b0;
			space_q <= 1'b0;
			aux_rdy_ignore_q <= 1'b0;
			aux_ws_q <= 2'h0;
		end else if (wr_aux) begin
			block_size_q <= pwdata[`AUX_SIZE_HI:`AUX_SIZE_LO];
			pin_function_q <= pwdata[`AUX_PINFN_BIT];
			space_q <= pwdata[`AUX_SPACE_BIT];
			aux_rdy_ignore_q <= pwdata[`RDY_IGNORE_BIT];
			aux_ws_q <= pwdata[`WS_HI:`WS_LO];
		end
	end

	// Activation tracking: write to each register, or any touch of aux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mid_written_q <= 1'b0;
			aux_written_q <= 1'b0;
			aux_accessed_q <= 1'b0;
		end else begin
			if (wr_mid) begin
				mid_written_q <= 1'b1;
			end
			if (wr_aux) begin
				aux_written_q <= 1'b1;
			end
			if (access_done && hit_aux_cfg) begin
				aux_accessed_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic mid_enabled;
	logic upper_cs_enabled;
	logic upper_addr_enabled;
	logic [6:0] mid_mask;
	logic mid_hit;
	logic [1:0] mid_quarter;
	logic upper_region;
	logic [1:0] upper_hit;
	logic [3:0] mid_onehot;

	assign mid_enabled = mid_written_q && aux_written_q;
	assign upper_cs_enabled = pin_function_q && aux_written_q && peripheral_base_written;
	assign upper_addr_enabled = !pin_function_q && aux_accessed_q;
	assign mid_mask = block_mask(block_size_q);

	// Only memory cycles reach the midrange block, which is what lets it
	// share addresses with I/O-mapped peripherals
	assign mid_hit = mid_enabled && cycle_is_mem &&
		((cycle_addr[`ADDR_MSB:`MID_BLOCK_LSB] & ~mid_mask) == (mid_base_q & ~mid_mask));

	// Quarter index sits just below the block's top address bit
	assign mid_quarter = 2'(cycle_addr >> (`MID_QTR_LSB + int'(size_index(block_size_q))));

	always_comb begin
		mid_onehot = 4'h0;
		mid_onehot[mid_quarter] = 1'b1;
	end

	assign upper_region = upper_cs_enabled && (cycle_is_mem == space_q) &&
		(cycle_addr[`ADDR_MSB:`PER_BASE_LSB] == peripheral_base);
	assign upper_hit[0] = upper_region && (cycle_addr[`PER_SUB_HI:`PER_SUB_LO] == `PER_UPPER5_SUB);
	assign upper_hit[1] = upper_region && (cycle_addr[`PER_SUB_HI:`PER_SUB_LO] == `PER_UPPER6_SUB);

	// ****************************************************************
	// Ready path and wait-state timer
	// ****************************************************************
	logic ready_level;
	logic timer_start;
	logic timer_done;
	select_pkg::wait_count_t timer_ws;
	logic timer_ignore;

	ready_sync u_ready_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(ext_ready),
		.level_out(ready_level)
	);

	select_pkg::cycle_state_e state_q;
	logic cycle_is_mid_q;

	// Midrange has priority if software lets memory regions collide
	assign timer_ws = cycle_is_mid_q ? mid_ws_q : aux_ws_q;
	assign timer_ignore = cycle_is_mid_q ? mid_rdy_ignore_q : aux_rdy_ignore_q;
	assign timer_start = (state_q == select_pkg::ST_SELECT);

	wait_timer u_wait_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(timer_start),
		.wait_count(timer_ws),
		.ready_ignore(timer_ignore),
		.ready_level(ready_level),
		.done(timer_done)
	);

	// ****************************************************************
	// Bus cycle sequencing
	// ****************************************************************
	logic [3:0] mid_sel_pend_q;
	logic [1:0] upper_sel_pend_q;
	logic any_hit;

	assign any_hit = mid_hit || (|upper_hit);

	// Selects latched at address time, driven one cycle later with
	// the multiplexed address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= select_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				select_pkg::ST_IDLE: begin
					if (cycle_start && any_hit) begin
						state_q <= select_pkg::ST_SELECT;
					end
				end
				select_pkg::ST_SELECT: begin
					state_q <= select_pkg::ST_WAIT;
				end
				select_pkg::ST_WAIT: begin
					if (timer_done) begin
						state_q <= select_pkg::ST_END;
					end
				end
				select_pkg::ST_END: begin
					state_q <= select_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mid_sel_pend_q <= 4'h0;
			upper_sel_pend_q <= 2'h0;
			cycle_is_mid_q <= 1'b0;
		end else if (state_q == select_pkg::ST_IDLE && cycle_start) begin
			mid_sel_pend_q <= mid_hit ? mid_onehot : 4'h0;
			upper_sel_pend_q <= mid_hit ? 2'h0 : upper_hit;
			cycle_is_mid_q <= mid_hit;
		end
	end

	// Active low; high from reset until a hit is sequenced
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			midrange_selects_n <= 4'hf;
		end else if (state_q == select_pkg::ST_SELECT) begin
			midrange_selects_n <= ~mid_sel_pend_q;
		end else if (state_q == select_pkg::ST_END) begin
			midrange_selects_n <= 4'hf;
		end
	end

	// Latched a1 and a2 follow every bus cycle in address mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_peripheral_selects_n <= 2'h3;
		end else if (upper_addr_enabled) begin
			if (cycle_start) begin
				upper_peripheral_selects_n <= cycle_addr[`LAT_ADDR_HI:`LAT_ADDR_LO];
			end
		end else if (state_q == select_pkg::ST_SELECT) begin
			upper_peripheral_selects_n <= ~upper_sel_pend_q;
		end else if (state_q == select_pkg::ST_END || !upper_cs_enabled) begin
			upper_peripheral_selects_n <= 2'h3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_done <= 1'b0;
		end else begin
			cycle_done <= (state_q == select_pkg::ST_WAIT) && timer_done;
		end
	end

endmodule : midrange_peripheral_chip_select

`default_nettype wire

/* select_map.svh */
// Register indices, field positions and reset values of the select block
`ifndef SELECT_MAP_SVH
`define SELECT_MAP_SVH

// ****************************************************************
// Register indices and APB byte addresses
// ****************************************************************
`define MID_CFG_INDEX 8'ha6
`define AUX_CFG_INDEX 8'ha8
`define MID_CFG_ADDR {2'b00, `MID_CFG_INDEX, 2'b00}
`define AUX_CFG_ADDR {2'b00, `AUX_CFG_INDEX, 2'b00}

// ****************************************************************
// Auxiliary configuration fields
// ****************************************************************
`define AUX_SIZE_HI 14
`define AUX_SIZE_LO 8
`define AUX_PINFN_BIT 7
`define AUX_SPACE_BIT 6
`define AUX_RSVD_ONES 16'h8038

// ****************************************************************
// Midrange configuration fields
// ****************************************************************
`define MID_BASE_HI 15
`define MID_BASE_LO 9
`define MID_RSVD_ONES 16'h01f8

// Shared by both registers
`define RDY_IGNORE_BIT 2
`define WS_HI 1
`define WS_LO 0
`define CFG_RESET 16'h0000

// ****************************************************************
// Address geometry
// ****************************************************************
`define MID_BLOCK_LSB 13
`define MID_QTR_LSB 11
`define PER_BASE_LSB 11
`define PER_SUB_HI 10
`define PER_SUB_LO 8
`define PER_UPPER5_SUB 3'h5
`define PER_UPPER6_SUB 3'h6
`define UNMAPPED_DATA 32'h0000_0000
`define ADDR_MSB 19
`define LAT_ADDR_HI 2
`define LAT_ADDR_LO 1

`endif

/* select_pkg.sv */
// Types shared by the select block
`default_nettype none

package select_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SELECT = 2'b01,
		ST_WAIT = 2'b11,
		ST_END = 2'b10
	} cycle_state_e;

	typedef logic [1:0] wait_count_t;

endpackage : select_pkg

`default_nettype wire

/* ready_sync.sv */
// Three-stage synchroniser for the external ready pin
`default_nettype none

module ready_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_in,
	output logic level_out
);

	logic meta_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// Change accepted only once the two settled stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_out <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_out <= s3_q;
		end
	end

endmodule : ready_sync

`default_nettype wire

/* wait_timer.sv */
// Wait-state counter with optional external ready qualification
`default_nettype none

module wait_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire select_pkg::wait_count_t wait_count,
	input wire logic ready_ignore,
	input wire logic ready_level,
	output logic done
);

	select_pkg::wait_count_t count_q;
	logic ignore_q;
	logic active_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 2'h0;
			ignore_q <= 1'b1;
			active_q <= 1'b0;
		end else if (start) begin
			count_q <= wait_count;
			ignore_q <= ready_ignore;
			active_q <= 1'b1;
		end else if (active_q) begin
			if (count_q != 2'h0) begin
				count_q <= count_q - 2'h1;
			end else if (ignore_q || ready_level) begin
				active_q <= 1'b0;
			end
		end
	end

	// Waits run out first; ready is then needed unless ignored
	assign done = active_q && (count_q == 2'h0) && (ignore_q || ready_level);

endmodule : wait_timer

`default_nettype wire

/* select_sva.sv */
// Port checker for the chip-select block
`default_nettype none
module select_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cycle_start,
	input wire logic cycle_done,
	input wire logic [3:0] midrange_selects_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************
	// Select sequences, select and APB checks
	// ****************
	sequence sel_on;
		$fell(&midrange_selects_n);
	endsequence
	sequence sel_held;
		!(&midrange_selects_n) && !cycle_done;
	endsequence
	chk_sel_onehot: assert property ($onehot0(~midrange_selects_n))
		else $error("midrange selects not one-hot");
	chk_sel_launch: assert property (sel_on |-> $past(cycle_start, 2))
		else $error("select not two edges after start");
	chk_sel_ends: assert property (sel_on |-> ##[1:60] cycle_done)
		else $error("select without done");
	chk_sel_stable: assert property (sel_held |=> $stable(midrange_selects_n))
		else $error("select moved mid-cycle");
	chk_sel_release: assert property (cycle_done && !(&midrange_selects_n) |=> &midrange_selects_n)
		else $error("select held past done");
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_apb_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_apb_error: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
endmodule : select_sva

bind midrange_peripheral_chip_select select_sva u_select_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_start(cycle_start),
	.cycle_done(cycle_done), .midrange_selects_n(midrange_selects_n));
`default_nettype wire

/* select_partner.sv */
// Memory and peripheral device model that answers with ready
`default_nettype none
module select_partner (
	input wire logic pclk,
	input wire logic [3:0] midrange_selects_n,
	input wire logic [1:0] upper_peripheral_selects_n,
	input wire logic [3:0] lat,
	output logic ext_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic idle;
	assign idle = &midrange_selects_n && &upper_peripheral_selects_n;
	always_ff @(posedge pclk) begin
		if (idle) cnt_q <= 4'h0;
		else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
	end
	// Ready drops when deselected so a stale level never passes
	assign ext_ready = !idle && cnt_q >= lat;
endmodule : select_partner
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the chip-select block
`include "select_map.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_start, cycle_is_mem, cycle_done;
	logic peripheral_base_written, ext_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] cycle_addr;
	logic [8:0] peripheral_base;
	logic [3:0] midrange_selects_n, ms, lat;
	logic [1:0] upper_peripheral_selects_n, us;
	logic e;
	int mismatches, checks_done, n;
	midrange_peripheral_chip_select u_midrange_peripheral_chip_select (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cycle_start(cycle_start), .cycle_addr(cycle_addr),
		.cycle_is_mem(cycle_is_mem), .peripheral_base(peripheral_base),
		.peripheral_base_written(peripheral_base_written), .ext_ready(ext_ready), .cycle_done(cycle_done),
		.midrange_selects_n(midrange_selects_n), .upper_peripheral_selects_n(upper_peripheral_selects_n));
	select_partner u_select_partner (.pclk(pclk), .midrange_selects_n(midrange_selects_n),
		.upper_peripheral_selects_n(upper_peripheral_selects_n), .lat(lat), .ext_ready(ext_ready));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic mid(input logic [6:0] b, input logic r, input logic [1:0] w);
		apb(1'b1, `MID_CFG_ADDR, {16'h0000, b, 6'h3f, r, w});
	endtask : mid
	task automatic aux(input logic [6:0] s, input logic x, input logic m, input logic r, input logic [1:0] w);
		apb(1'b1, `AUX_CFG_ADDR, {16'h0000, 1'b1, s, x, m, 3'h7, r, w});
	endtask : aux
	task automatic cy(input string what, input logic [19:0] a, input logic mem, input logic [3:0] ems,
		input logic [1:0] eus, input int en);
		@(posedge pclk);
		cycle_start <= 1'b1;
		cycle_addr <= a;
		cycle_is_mem <= mem;
		n = 0;
		// Edges counted from the one that samples cycle_start
		for (int i = 1; i < 40 && n == 0; i++) begin
			@(posedge pclk);
			cycle_start <= 1'b0;
			#1;
			if (i == 2) begin
				ms = midrange_selects_n;
				us = upper_peripheral_selects_n;
			end
			if (cycle_done === 1'b1) n = i;
		end
		repeat (2) @(posedge pclk);
		check(what, 32'(ms), 32'(ems));
		check(what, 32'(us), 32'(eus));
		if (en >= 0) check(what, 32'(n), 32'(en));
	endtask : cy
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		check("reset mid", 32'(midrange_selects_n), 32'h0000_000f);
		check("reset upper", 32'(upper_peripheral_selects_n), 32'h0000_0003);
		apb(1'b0, `MID_CFG_ADDR, 32'h0000_0000);
		check("mid read", q, 32'h0000_01f8);
		cy("no access", 20'h0_0002, 1'b0, 4'hf, 2'h3, 0);
		mid(7'h00, 1'b1, 2'h0);
		cy("mid only", 20'h0_0100, 1'b1, 4'hf, 2'h3, 0);
		apb(1'b0, `AUX_CFG_ADDR, 32'h0000_0000);
		check("aux read", q, 32'h0000_8038);
		cy("aux read pins", 20'h0_0002, 1'b0, 4'hf, 2'h1, 0);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check("unmapped err", {31'h0, e}, 32'h0000_0001);
		check("unmapped data", q, 32'h0000_0000);
		aux(7'h01, 1'b1, 1'b0, 1'b1, 2'h0);
		cy("both written", 20'h0_0100, 1'b1, 4'he, 2'h3, 3);
		cy("base unset", 20'h0_0500, 1'b0, 4'hf, 2'h3, 0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sizes();
		logic [19:0] base, qsz;
		for (int k = 0; k < 7; k++) begin
			base = 20'h0_2000 << k;
			qsz = 20'h0_0800 << k;
			mid(7'(1 << k), 1'b1, 2'h0);
			aux(7'(1 << k), 1'b1, 1'b0, 1'b1, 2'h0);
			cy("below", base - 20'h0_0002, 1'b1, 4'hf, 2'h3, 0);
			cy("above", base + (qsz << 2), 1'b1, 4'hf, 2'h3, 0);
			for (int j = 0; j < 4; j++)
				cy("quarter", base + qsz * 20'(j + 1) - 20'h0_0002, 1'b1, ~(4'h1 << j), 2'h3, 3);
		end
		cy("io miss", 20'h8_0000, 1'b0, 4'hf, 2'h3, 0);
		$display("size test done");
	endtask : t_sizes
	task automatic t_waits();
		lat <= 4'hf;
		for (int w = 0; w < 4; w++) begin
			mid(7'h01, 1'b1, 2'(w));
			cy("mid waits", 20'h0_2000, 1'b1, 4'he, 2'h3, 3 + w);
		end
		peripheral_base <= 9'h000;
		peripheral_base_written <= 1'b1;
		mid(7'h10, 1'b1, 2'h0);
		for (int w = 0; w < 4; w++) begin
			aux(7'h01, 1'b1, 1'b0, 1'b1, 2'(w));
			cy("upper waits", 20'h0_0500, 1'b0, 4'hf, 2'h2, 3 + w);
		end
		cy("upper six", 20'h0_0600, 1'b0, 4'hf, 2'h1, 6);
		lat <= 4'h6;
		aux(7'h01, 1'b1, 1'b0, 1'b0, 2'h0);
		cy("upper ready", 20'h0_0500, 1'b0, 4'hf, 2'h2, -1);
		check("upper ready", 32'(n > 8), 32'h0000_0001);
		mid(7'h10, 1'b0, 2'h0);
		cy("mid ready", 20'h2_0000, 1'b1, 4'he, 2'h3, -1);
		check("mid ready", 32'(n > 8), 32'h0000_0001);
		$display("wait test done");
	endtask : t_waits
	task automatic t_space();
		aux(7'h01, 1'b1, 1'b1, 1'b1, 2'h0);
		cy("mem space io", 20'h0_0500, 1'b0, 4'hf, 2'h3, 0);
		cy("mem space mem", 20'h0_0500, 1'b1, 4'hf, 2'h2, 3);
		aux(7'h01, 1'b1, 1'b0, 1'b1, 2'h0);
		mid(7'h00, 1'b1, 2'h0);
		cy("overlap mem", 20'h0_0500, 1'b1, 4'he, 2'h3, 3);
		cy("overlap io", 20'h0_0500, 1'b0, 4'hf, 2'h2, 3);
		aux(7'h01, 1'b0, 1'b0, 1'b1, 2'h0);
		apb(1'b0, `AUX_CFG_ADDR, 32'h0000_0000);
		check("aux back", q, 32'h0000_813c);
		for (int j = 0; j < 4; j++)
			cy("addr pins", 20'(j * 2), 1'b0, 4'hf, 2'(j), 0);
		$display("space test done");
	endtask : t_space
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	initial begin
		{presetn, psel, penable, pwrite, cycle_start, cycle_is_mem, peripheral_base_written} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		cycle_addr = 20'h0_0000;
		peripheral_base = 9'h000;
		lat = 4'h2;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		t_reset();
		t_sizes();
		t_waits();
		t_space();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
